/* File: hw/mdc_pkg.sv */
// Purpose: shared constants for the metering detect control block
// Assumes: ahb-lite slave, 32-bit data, one word per register
// Notes:   printed offsets are not word multiples, so they are indices
package mdc_pkg;
    localparam logic [15:0] IDX_NOLOAD_STATUS = 16'h287f;
    localparam logic [15:0] IDX_DETECT_CTRL   = 16'h2886;
    localparam logic [15:0] IDX_FIRST_DELAY   = 16'h287b;
    localparam logic [15:0] IDX_SECOND_DELAY  = 16'h287c;
    localparam logic [15:0] IDX_NOLOAD_EN     = 16'h287d;
    localparam logic [15:0] IDX_IRQ_STATUS    = 16'h2890;
    localparam logic [15:0] IDX_IRQ_MASK      = 16'h2891;
    localparam logic [15:0] IDX_THRESHOLD     = 16'h2892;
    localparam int          ADDR_W            = 18;

    localparam logic [7:0] RST_BYTE = 8'h00;

    // noload_status_phase_low fields
    localparam int B_PATH1_CREEP  = 7;
    localparam int B_PATH2_CREEP  = 6;
    localparam int F_PULSE_LO     = 4;
    localparam int F_I2_LO        = 2;
    localparam int F_I1_LO        = 0;
    // current_detect_ctrl fields
    localparam int B_GATE         = 7;
    localparam int B_SEEN         = 6;
    localparam int B_CLEAR        = 5;
    localparam int B_DET_EN       = 4;
    localparam int F_COUNT_LO     = 0;
    // delay ctrl fields
    localparam int B_DELAY_TARGET = 7;
    // noload enable fields
    localparam int B_PATH2_NL_EN  = 7;
    localparam int B_PATH1_NL_EN  = 6;
    // interrupt status bits
    localparam int IRQ_SEEN       = 0;
    localparam int IRQ_CREEP1     = 1;
    localparam int IRQ_CREEP2     = 2;
    localparam int IRQ_W          = 3;

    // pulse width, in ms, by code
    localparam int PULSE_MS_0 = 80;
    localparam int PULSE_MS_1 = 40;
    localparam int PULSE_MS_2 = 20;
    localparam int PULSE_MS_3 = 10;
    localparam int CLK_HZ     = 200_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam logic [23:0] PULSE_CYC_0 = 24'(PULSE_MS_0 * CYC_PER_MS);
    localparam logic [23:0] PULSE_CYC_1 = 24'(PULSE_MS_1 * CYC_PER_MS);
    localparam logic [23:0] PULSE_CYC_2 = 24'(PULSE_MS_2 * CYC_PER_MS);
    localparam logic [23:0] PULSE_CYC_3 = 24'(PULSE_MS_3 * CYC_PER_MS);

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    typedef enum logic [1:0] {
        MDC_TGT_I2  = 2'b00,
        MDC_TGT_VLT = 2'b01
    } mdc_target_t;
endpackage

/* File: hw/mdc_metering_detect_control.sv */
// Purpose: control/status registers of the metering front end
// Assumes: datapath supplies sample strobes, creep levels, pulse requests
// Notes:   one clock domain; creep inputs are synchronised
//
// Operation
// (R1) path1 creep flag reads 1 while path 1 creeps, 0 while metering
// (R2) path2 creep flag reads 1 while path 2 creeps, 0 while metering
// (R3) pulse width code 00/01/10/11 gives 80/40/20/10 ms
// (R4) i2 delay is second_delay_ctrl[5:0] above low bits [3:2]
// (R5) i1 delay is first_delay_ctrl[5:0] above low bits [1:0]
// (R6) one delay step is 0.0055 degree at 3.2768 MHz sampling
// (R7) gate bit stops sampling and power/rms, accumulation keeps running
// (R8) software sets pulse threshold before setting the gate bit
// (R9) software should gate when accumulating a constant
// (R10) seen flag sticks until clear bit is 1 or detection disabled
// (R11) software writes clear 1 then back to 0
// (R12) current detection runs only while its enable bit is 1
// (R13) seen set after count+1 consecutive samples above threshold
// (R14) each path's no-load detection runs only under its own enable
// (R15) delay target bit 1 delays voltage, 0 delays second current
// (R16) any sample not above threshold restarts the run count
`timescale 1ns/1ps
`default_nettype none
module mdc_metering_detect_control
    import mdc_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic               path1_creep_in,
    input  wire logic               path2_creep_in,
    input  wire logic               sample_valid,
    input  wire logic signed [31:0] i1_ac_sample,
    input  wire logic               pulse_request,
    output logic                    energy_pulse_out,
    output logic [7:0]              i1_delay_setting,
    output logic [7:0]              i2_delay_setting,
    output logic                    delay_target_voltage,
    output logic                    sampling_enable,
    output logic                    power_rms_enable,
    output logic                    path1_noload_enable,
    output logic                    path2_noload_enable,
    output logic                    irq
);

////////////////////////////////////////////////////////////////////////////////
// bus slave

    logic [7:0]        status_reg;
    logic [7:0]        detect_reg;
    logic [7:0]        first_delay_ctrl_reg;
    logic [7:0]        second_delay_ctrl_reg;
    logic [7:0]        noload_en_reg;
    logic [IRQ_W-1:0]  irq_status_reg;
    logic [IRQ_W-1:0]  irq_mask_reg;
    logic [31:0]       threshold_reg;
    logic              wr_pend_reg;
    logic [15:0]       wr_idx_reg;
    logic [31:0]       hrdata_reg;

    function automatic logic [15:0] word_idx(input logic [31:0] a);
        word_idx = a[ADDR_W-1:2];
    endfunction

    wire        addr_ok  = hsel && hready && (htrans == HTRANS_NONSEQ);
    wire        rd_take  = addr_ok && !hwrite;
    wire        wr_take  = addr_ok && hwrite;
    wire [15:0] rd_idx   = word_idx(haddr);
    wire        wr_do    = wr_pend_reg;
    wire [7:0]  wbyte    = hwdata[7:0];

    wire wr_status = wr_do && (wr_idx_reg == IDX_NOLOAD_STATUS);
    wire wr_detect = wr_do && (wr_idx_reg == IDX_DETECT_CTRL);
    wire wr_first  = wr_do && (wr_idx_reg == IDX_FIRST_DELAY);
    wire wr_second = wr_do && (wr_idx_reg == IDX_SECOND_DELAY);
    wire wr_nl_en  = wr_do && (wr_idx_reg == IDX_NOLOAD_EN);
    wire wr_istat  = wr_do && (wr_idx_reg == IDX_IRQ_STATUS);
    wire wr_imask  = wr_do && (wr_idx_reg == IDX_IRQ_MASK);
    wire wr_thr    = wr_do && (wr_idx_reg == IDX_THRESHOLD);

    // unmapped indices read zero and ignore writes
    logic [31:0] rd_mux;
    always_comb begin
        case (rd_idx)
            IDX_NOLOAD_STATUS: rd_mux = {24'h000000, status_reg};
            IDX_DETECT_CTRL:   rd_mux = {24'h000000, detect_reg};
            IDX_FIRST_DELAY:   rd_mux = {24'h000000, first_delay_ctrl_reg};
            IDX_SECOND_DELAY:  rd_mux = {24'h000000, second_delay_ctrl_reg};
            IDX_NOLOAD_EN:     rd_mux = {24'h000000, noload_en_reg};
            IDX_IRQ_STATUS:    rd_mux = {29'h00000000, irq_status_reg};
            IDX_IRQ_MASK:      rd_mux = {29'h00000000, irq_mask_reg};
            IDX_THRESHOLD:     rd_mux = threshold_reg;
            default:           rd_mux = 32'h00000000;
        endcase
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 16'h0000;
            hrdata_reg  <= 32'h00000000;
        end else begin
            wr_pend_reg <= wr_take;
            wr_idx_reg  <= rd_idx;
            if (rd_take) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// creep inputs: two-stage synchronisers

    logic [1:0] creep_meta_reg;
    logic [1:0] creep_sync_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            creep_meta_reg <= 2'b00;
            creep_sync_reg <= 2'b00;
        end else begin
            creep_meta_reg <= {path2_creep_in, path1_creep_in};
            creep_sync_reg <= creep_meta_reg;
        end
    end

    // a disabled path reports metering, never creep
    wire path1_creep = creep_sync_reg[0] && noload_en_reg[B_PATH1_NL_EN]; // (R14)
    wire path2_creep = creep_sync_reg[1] && noload_en_reg[B_PATH2_NL_EN]; // (R14)

////////////////////////////////////////////////////////////////////////////////
// control registers

    wire [1:0] pulse_width_sel   = status_reg[F_PULSE_LO +: 2];
    wire [1:0] i2_delay_low_bits = status_reg[F_I2_LO +: 2];
    wire [1:0] i1_delay_low_bits = status_reg[F_I1_LO +: 2];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status_reg <= RST_BYTE;
        end else begin
            status_reg[B_PATH1_CREEP] <= path1_creep; // (R1)
            status_reg[B_PATH2_CREEP] <= path2_creep; // (R2)
            if (wr_status) begin
                status_reg[5:0] <= wbyte[5:0];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            first_delay_ctrl_reg  <= RST_BYTE;
            second_delay_ctrl_reg <= RST_BYTE;
            noload_en_reg         <= RST_BYTE;
            threshold_reg         <= 32'h00000000;
            irq_mask_reg          <= '0;
        end else begin
            if (wr_first)  first_delay_ctrl_reg  <= wbyte;
            if (wr_second) second_delay_ctrl_reg <= wbyte;
            if (wr_nl_en)  noload_en_reg         <= wbyte;
            if (wr_thr)    threshold_reg         <= hwdata;
            if (wr_imask)  irq_mask_reg          <= wbyte[IRQ_W-1:0];
        end
    end

    // step size follows from the sampling clock of the delay line
    assign i1_delay_setting = {first_delay_ctrl_reg[5:0], i1_delay_low_bits};  // (R5) (R6)
    assign i2_delay_setting = {second_delay_ctrl_reg[5:0], i2_delay_low_bits}; // (R4) (R6)
    assign delay_target_voltage = second_delay_ctrl_reg[B_DELAY_TARGET];       // (R15)
    assign path1_noload_enable  = noload_en_reg[B_PATH1_NL_EN];                // (R14)
    assign path2_noload_enable  = noload_en_reg[B_PATH2_NL_EN];                // (R14)

////////////////////////////////////////////////////////////////////////////////
// current detection

    wire        analog_gate_ctrl      = detect_reg[B_GATE];
    wire        current_detect_enable = detect_reg[B_DET_EN];
    wire        seen_flag_clear       = detect_reg[B_CLEAR];
    wire [3:0]  detect_sample_count   = detect_reg[F_COUNT_LO +: 4];
    wire signed [31:0] current_detect_threshold = threshold_reg;

    // gating only the front end keeps accumulation alive on a constant
    assign sampling_enable  = !analog_gate_ctrl; // (R7)
    assign power_rms_enable = !analog_gate_ctrl; // (R7)

    logic [4:0] run_reg;
    wire        above    = i1_ac_sample > current_detect_threshold;
    wire        smp      = sample_valid && current_detect_enable && sampling_enable; // (R12)
    wire [4:0]  run_inc  = run_reg + 5'h01;
    wire [4:0]  run_goal = {1'b0, detect_sample_count} + 5'h01;
    wire        caught   = smp && above && (run_inc >= run_goal); // (R13)

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            run_reg <= 5'h00;
        end else if (!current_detect_enable || (smp && !above)) begin
            run_reg <= 5'h00; // (R16)
        end else if (smp && !caught) begin
            run_reg <= run_inc;
        end
    end

    // detection hit wins over a clear in the same cycle
    wire seen_clr = seen_flag_clear || !current_detect_enable; // (R10)

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            detect_reg <= RST_BYTE;
        end else begin
            if (wr_detect) begin
                detect_reg[B_GATE]   <= wbyte[B_GATE];
                detect_reg[B_CLEAR:0] <= wbyte[B_CLEAR:0];
            end
            if (caught) begin
                detect_reg[B_SEEN] <= 1'b1; // (R13)
            end else if (seen_clr) begin
                detect_reg[B_SEEN] <= 1'b0; // (R10) (R11)
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// interrupts: sticky, write one to clear, set wins

    logic [1:0] creep_prev_reg;
    wire  [IRQ_W-1:0] irq_evt = {path2_creep && !creep_prev_reg[1],
                                 path1_creep && !creep_prev_reg[0],
                                 caught};
    wire  [IRQ_W-1:0] irq_w1c = wr_istat ? wbyte[IRQ_W-1:0] : '0;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_status_reg <= '0;
            creep_prev_reg <= 2'b00;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_w1c) | irq_evt;
            creep_prev_reg <= {path2_creep, path1_creep};
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

////////////////////////////////////////////////////////////////////////////////
// energy pulse width

    logic [23:0] pulse_cnt_reg;
    logic        pulse_reg;
    logic [23:0] pulse_len;

    always_comb begin
        case (pulse_width_sel)
            2'h0:    pulse_len = PULSE_CYC_0; // (R3)
            2'h1:    pulse_len = PULSE_CYC_1; // (R3)
            2'h2:    pulse_len = PULSE_CYC_2; // (R3)
            default: pulse_len = PULSE_CYC_3; // (R3)
        endcase
    end

    // requests during a pulse are dropped; the datapath spaces them
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pulse_reg     <= 1'b0;
            pulse_cnt_reg <= 24'h000000;
        end else if (!pulse_reg && pulse_request) begin
            pulse_reg     <= 1'b1;
            pulse_cnt_reg <= pulse_len - 24'h000001;
        end else if (pulse_reg) begin
            if (pulse_cnt_reg == 24'h000000) begin
                pulse_reg <= 1'b0;
            end else begin
                pulse_cnt_reg <= pulse_cnt_reg - 24'h000001;
            end
        end
    end

    assign energy_pulse_out = pulse_reg;

endmodule // mdc_metering_detect_control
`default_nettype wire

/* File: dv/mdc_ctrl_monitor.sv */
// Purpose: port-level assertions for the metering detect control block
// Assumes: one clock, asynchronous active-high reset
// Notes:   sees only top-level ports; bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module mdc_ctrl_monitor
    import mdc_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       pulse_request,
    input wire logic       energy_pulse_out,
    input wire logic [7:0] i1_delay_setting,
    input wire logic [7:0] i2_delay_setting,
    input wire logic       delay_target_voltage,
    input wire logic       sampling_enable,
    input wire logic       power_rms_enable,
    input wire logic       path1_noload_enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic wr_addr;
    assign wr_addr = hsel && hready && hwrite && (htrans == HTRANS_NONSEQ);
    ////////////////////////////////////////////////////////////////////////
    sequence s_pulse_go;
        pulse_request && !energy_pulse_out ##1 energy_pulse_out;
    endsequence
    sequence s_pulse_held;
        energy_pulse_out [*8];
    endsequence
    property p_ok; hresp == 1'b0 && hreadyout == 1'b1; endproperty
    property p_pulse_start; pulse_request && !energy_pulse_out |-> s_pulse_go; endproperty
    property p_pulse_cause; $rose(energy_pulse_out) |-> $past(pulse_request); endproperty
    property p_pulse_min; $rose(energy_pulse_out) |-> s_pulse_held; endproperty
    property p_gate_pair; sampling_enable == power_rms_enable; endproperty
    // settings only move two edges after a write address phase
    property p_i1_wr; $changed(i1_delay_setting) |-> $past(wr_addr, 2); endproperty
    property p_i2_wr; $changed(i2_delay_setting) |-> $past(wr_addr, 2); endproperty
    property p_tgt_wr; $changed(delay_target_voltage) |-> $past(wr_addr, 2); endproperty
    property p_nl_wr; $changed(path1_noload_enable) |-> $past(wr_addr, 2); endproperty
    property p_gate_wr; $changed(sampling_enable) |-> $past(wr_addr, 2); endproperty
    a_ok: assert property (p_ok) else $error("bus response not okay");
    a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");
    a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without request");
    a_pulse_min: assert property (p_pulse_min) else $error("pulse too short");
    a_gate_pair: assert property (p_gate_pair) else $error("gate enables differ");
    a_i1_wr: assert property (p_i1_wr) else $error("i1 delay moved alone");
    a_i2_wr: assert property (p_i2_wr) else $error("i2 delay moved alone");
    a_tgt_wr: assert property (p_tgt_wr) else $error("target moved alone");
    a_nl_wr: assert property (p_nl_wr) else $error("noload enable moved alone");
    a_gate_wr: assert property (p_gate_wr) else $error("gate moved alone");
endmodule // mdc_ctrl_monitor
bind mdc_metering_detect_control mdc_ctrl_monitor i_mdc_ctrl_monitor (
    .sys_clk, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .pulse_request, .energy_pulse_out, .i1_delay_setting, .i2_delay_setting,
    .delay_target_voltage, .sampling_enable, .power_rms_enable, .path1_noload_enable
);
`default_nettype wire

/* File: dv/mdc_metering_detect_control_tb.sv */
// Purpose: register-level testbench for the metering detect control block
// Assumes: zero-wait ahb-lite slave, hready looped from hreadyout
// Notes:   pulse widths are millions of cycles, so only the start is seen
`timescale 1ns/1ps
`default_nettype none
module mdc_metering_detect_control_tb
    import mdc_pkg::*;
;
    logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = HSIZE_WORD;
    logic creep1 = 0, creep2 = 0, sample_valid = 0, pulse_request = 0, pulse_out;
    logic signed [31:0] i1_ac_sample = 0;
    logic [7:0] i1_d, i2_d;
    logic tgt, samp_en, pwr_en, nl1, nl2;
    int err_count = 0, num_checks = 0;
    logic [15:0] idxs [8] = '{IDX_NOLOAD_STATUS, IDX_DETECT_CTRL, IDX_FIRST_DELAY,
        IDX_SECOND_DELAY, IDX_NOLOAD_EN, IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_THRESHOLD};
    always #2.5 sys_clk = ~sys_clk;
    mdc_metering_detect_control i_mdc_metering_detect_control (
        .sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .path1_creep_in(creep1), .path2_creep_in(creep2), .sample_valid, .i1_ac_sample,
        .pulse_request, .energy_pulse_out(pulse_out), .i1_delay_setting(i1_d),
        .i2_delay_setting(i2_d), .delay_target_voltage(tgt), .sampling_enable(samp_en),
        .power_rms_enable(pwr_en), .path1_noload_enable(nl1), .path2_noload_enable(nl2), .irq
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one single transfer; read data taken at the data-phase edge
    task automatic bus(input logic [15:0] idx, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {14'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(idx, 1'b1, d, x);
    endtask
    task automatic rc(input logic [15:0] idx, input logic [31:0] e);
        logic [31:0] x;
        bus(idx, 1'b0, 32'h0, x);
        chk($sformatf("reg %h", idx), e, x);
    endtask
    task automatic smp(input logic signed [31:0] v);
        sample_valid <= 1'b1;
        i1_ac_sample <= v;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
        @(posedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        foreach (idxs[i]) rc(idxs[i], 32'h0);
        wr(IDX_FIRST_DELAY, 32'h2a);
        wr(IDX_SECOND_DELAY, 32'h95);
        wr(IDX_NOLOAD_STATUS, 32'hf9);
        @(posedge sys_clk);
        chk("i1 delay", 32'ha9, {24'h0, i1_d});
        chk("i2 delay", 32'h56, {24'h0, i2_d});
        chk("target", 32'h1, {31'h0, tgt});
        rc(IDX_NOLOAD_STATUS, 32'h39);
        wr(IDX_SECOND_DELAY, 32'h15);
        @(posedge sys_clk);
        chk("target", 32'h0, {31'h0, tgt});
        // creep flags and their interrupts
        wr(IDX_NOLOAD_EN, 32'h40);
        wr(IDX_IRQ_MASK, 32'h6);
        creep1 <= 1'b1;
        creep2 <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk("noload en", 32'h1, {30'h0, nl2, nl1});
        rc(IDX_NOLOAD_STATUS, 32'hb9);
        chk("irq", 32'h1, {31'h0, irq});
        wr(IDX_NOLOAD_EN, 32'hc0);
        repeat (5) @(posedge sys_clk);
        rc(IDX_NOLOAD_STATUS, 32'hf9);
        creep1 <= 1'b0;
        creep2 <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rc(IDX_NOLOAD_STATUS, 32'h39);
        wr(IDX_IRQ_STATUS, 32'h7);
        @(posedge sys_clk);
        chk("irq", 32'h0, {31'h0, irq});
        // current detection run, clear and disable
        wr(IDX_THRESHOLD, 32'd100);
        wr(IDX_DETECT_CTRL, 32'h13);
        repeat (3) smp(200);
        smp(100);
        repeat (3) smp(150);
        rc(IDX_DETECT_CTRL, 32'h13);
        smp(101);
        rc(IDX_DETECT_CTRL, 32'h53);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(IDX_IRQ_MASK, 32'h1);
        @(posedge sys_clk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(IDX_DETECT_CTRL, 32'h33);
        // the clear bit acts one edge after it lands, so let that edge pass
        @(posedge sys_clk);
        rc(IDX_DETECT_CTRL, 32'h33);
        wr(IDX_DETECT_CTRL, 32'h13);
        rc(IDX_DETECT_CTRL, 32'h13);
        wr(IDX_IRQ_STATUS, 32'h1);
        @(posedge sys_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(IDX_DETECT_CTRL, 32'h03);
        repeat (4) smp(200);
        rc(IDX_DETECT_CTRL, 32'h03);
        wr(IDX_DETECT_CTRL, 32'h10);
        smp(-5);
        rc(IDX_DETECT_CTRL, 32'h10);
        smp(101);
        rc(IDX_DETECT_CTRL, 32'h50);
        wr(IDX_DETECT_CTRL, 32'h00);
        @(posedge sys_clk);
        rc(IDX_DETECT_CTRL, 32'h00);
        // gate stops sampling and power paths
        wr(IDX_DETECT_CTRL, 32'h90);
        @(posedge sys_clk);
        chk("gated enables", 32'h0, {30'h0, samp_en, pwr_en});
        smp(500);
        rc(IDX_DETECT_CTRL, 32'h90);
        wr(IDX_DETECT_CTRL, 32'h10);
        @(posedge sys_clk);
        chk("enables", 32'h3, {30'h0, samp_en, pwr_en});
        wr(16'h287e, 32'hff);
        rc(16'h287e, 32'h0);
        // energy pulse, width code 11 still selected
        pulse_request <= 1'b1;
        @(posedge sys_clk);
        pulse_request <= 1'b0;
        @(posedge sys_clk);
        chk("pulse", 32'h1, {31'h0, pulse_out});
        repeat (1000) @(posedge sys_clk);
        chk("pulse held", 32'h1, {31'h0, pulse_out});
        wrap_up();
    end
endmodule // mdc_metering_detect_control_tb
`default_nettype wire
